//--- hw/uarx_pkg.sv
package uarx_pkg;
	// Oversampling ratios per bit.
	localparam int unsigned UARX_OSR_NORMAL = 16;
	localparam int unsigned UARX_OSR_DOUBLE = 8;
	// First of the three centre samples (middle is +1, last is +2).
	localparam logic [3:0] UARX_SF_NORMAL = 4'h8;
	localparam logic [3:0] UARX_SF_DOUBLE = 4'h4;
	// Frame length limits for data plus parity bits.
	localparam logic [3:0] UARX_BITS_MIN = 4'h5;
	localparam logic [3:0] UARX_BITS_MAX = 4'hA;
	localparam logic [3:0] UARX_BITS_RST = 4'h8;
	// Receiver states, Gray coded along hunt, start, data, stop.
	typedef enum logic [1:0] {
		UARX_HUNT = 2'b00,
		UARX_START = 2'b01,
		UARX_DATA = 2'b11,
		UARX_STOP = 2'b10
	} uarx_state_e;
endpackage : uarx_pkg

//--- hw/uarx_recovery.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Sample the line 16 times per bit, or 8 times in double speed.
// [R2] Start detection begins on a high to low edge; first low is sample one.
// [R3] Qualify the start with samples 8,9,10 or 4,5,6 in double speed.
// [R4] A majority high start is noise; resume hunting for a falling edge.
// [R5] A valid start aligns bit timing; realign for every start bit.
// [R6] Per-bit state counter of 16 or 8 states numbers each sample.
// [R7] Each bit is the majority of its three centre samples.
// [R8] Recover bits through the first stop bit; ignore further stop bits.
// [R9] Vote the stop bit too; a zero stop bit raises the frame error flag.
// [R10] Hunt again right after the last voting sample of the stop bit.
// [R11] Accept five to ten data plus parity bits.
// [R12] The transmitter keeps its rate inside the accepted ratio band.
// [R13] Each end should use at most half the total rate error budget.
// [R14] Disabling the receiver abandons any frame at once.
// [R15] A start is only taken when the preceding sample was high.
module uarx_recovery #(
	parameter int unsigned MAX_BITS = 10
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rx_enable,
	input wire logic double_speed_select,
	input wire logic sample_tick,
	input wire logic serial_in,
	input wire logic [3:0] frame_bits,
	output logic [MAX_BITS-1:0] rx_data,
	output logic frame_error_flag,
	output logic frame_valid,
	output logic rx_busy
);
	import uarx_pkg::*;

	// Two of three vote, used for the start bit and every frame bit.
	function automatic logic uarx_vote(input logic [2:0] s);
		uarx_vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : uarx_vote

	uarx_state_e state_reg, state_next;
	logic [3:0] phase_reg, phase_next;
	logic [3:0] bitcnt_reg, bitcnt_next;
	logic [3:0] nbits_reg, nbits_next;
	logic [2:0] vote_reg, vote_next;
	logic prev_reg, prev_next;
	logic [MAX_BITS-1:0] shift_reg, shift_next;
	logic [MAX_BITS-1:0] data_reg, data_next;
	logic fe_reg, fe_next;
	logic valid_reg, valid_next;
	logic busy_reg, busy_next;

	logic [3:0] sf;
	logic [3:0] last_phase;
	logic bit_done;

	// The mode picks the first centre sample and the last state of a bit.
	assign sf = double_speed_select ? UARX_SF_DOUBLE : UARX_SF_NORMAL; // R3
	// State sixteen of a normal-mode bit is held as 0 in four bits, so the last state
	// is the ratio itself, cut to four bits on purpose.
	assign last_phase = double_speed_select ? 4'(UARX_OSR_DOUBLE) :
		4'(UARX_OSR_NORMAL); // R6
	// A bit is decided as soon as its third centre sample is in.
	assign bit_done = sample_tick && (phase_reg == sf + 4'h2); // R7

	// Next-state logic. Samples are only taken on sample_tick, which runs
	// at 16x or 8x the baud depending on the mode; the divider lives outside.
	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		bitcnt_next = bitcnt_reg;
		nbits_next = nbits_reg;
		vote_next = vote_reg;
		prev_next = prev_reg;
		shift_next = shift_reg;
		data_next = data_reg;
		fe_next = fe_reg;
		valid_next = 1'b0;
		busy_next = (state_reg != UARX_HUNT);
		// The tick's accuracy is this end's share of the rate error budget; keep it within half.
		if (sample_tick) begin // R13
			prev_next = serial_in; // R1
		end
		// Collect centre samples into the vote window.
		if (sample_tick && phase_reg >= sf && phase_reg <= sf + 4'h2) begin
			vote_next = {vote_reg[1:0], serial_in}; // R7
		end
		case (state_reg)
			UARX_HUNT: begin
				if (sample_tick && prev_reg && !serial_in) begin // R2 R15
					state_next = UARX_START;
					phase_next = 4'h2; // R2
					bitcnt_next = 4'h0;
					// Clamp the frame size so a bad setting cannot hang.
					if (frame_bits < UARX_BITS_MIN) begin
						nbits_next = UARX_BITS_MIN; // R11
					end else if (frame_bits > 4'(MAX_BITS)) begin
						nbits_next = 4'(MAX_BITS); // R11
					end else begin
						nbits_next = frame_bits; // R11
					end
				end
			end
			UARX_START: begin
				if (bit_done) begin
					if (uarx_vote({vote_reg[1:0], serial_in})) begin
						state_next = UARX_HUNT; // R4
					end else begin
						state_next = UARX_DATA; // R5
					end
				end
			end
			UARX_DATA: begin
				if (bit_done) begin
					// LSB first: shift in from the top, then right-justify at the end.
					shift_next = {uarx_vote({vote_reg[1:0], serial_in}),
						shift_reg[MAX_BITS-1:1]}; // R7
					bitcnt_next = bitcnt_reg + 4'h1;
					if (bitcnt_reg + 4'h1 == nbits_reg) begin
						state_next = UARX_STOP; // R8
					end
				end
			end
			UARX_STOP: begin
				if (bit_done) begin
					// Returning straight to hunt lets a start follow the vote.
					state_next = UARX_HUNT; // R10
					fe_next = !uarx_vote({vote_reg[1:0], serial_in}); // R9
					data_next = shift_reg >> (4'(MAX_BITS) - nbits_reg);
					valid_next = 1'b1; // R8
				end
			end
			default: begin
				state_next = UARX_HUNT;
			end
		endcase
		// Phase counter wraps at the mode's last state; the start edge realigns it.
		if (sample_tick && state_reg != UARX_HUNT) begin
			phase_next = (phase_reg == last_phase) ? 4'h1 : phase_reg + 4'h1; // R6
		end
		// Disabling drops the frame at once; hold idle so a stale low is no start.
		if (!rx_enable) begin
			state_next = UARX_HUNT; // R14
			prev_next = 1'b0;
			valid_next = 1'b0;
		end
	end

	// State registers.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= UARX_HUNT;
			phase_reg <= 4'h0;
			bitcnt_reg <= 4'h0;
			nbits_reg <= UARX_BITS_RST;
			vote_reg <= 3'h7;
			prev_reg <= 1'b0;
			shift_reg <= '0;
			data_reg <= '0;
			fe_reg <= 1'b0;
			valid_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			bitcnt_reg <= bitcnt_next;
			nbits_reg <= nbits_next;
			vote_reg <= vote_next;
			prev_reg <= prev_next;
			shift_reg <= shift_next;
			data_reg <= data_next;
			fe_reg <= fe_next;
			valid_reg <= valid_next;
			busy_reg <= busy_next;
		end
	end

	assign rx_data = data_reg;
	assign frame_error_flag = fe_reg;
	assign frame_valid = valid_reg;
	assign rx_busy = busy_reg;

	// A falling edge while hunting starts detection on the next cycle.
	sequence s_fall;
		rx_enable && state_reg == UARX_HUNT && sample_tick && prev_reg && !serial_in;
	endsequence
	AST_START_DETECT: assert property (@(posedge clk) disable iff (sys_rst) // R2
		s_fall |=> state_reg == UARX_START && phase_reg == 4'h2)
		else $error("Start edge not taken.");
	AST_NO_START_LOW_PREV: assert property (@(posedge clk) disable iff (sys_rst) // R15
		(state_reg == UARX_HUNT && !prev_reg) |=> state_reg != UARX_START)
		else $error("Start taken without a high sample before.");
	AST_NOISE_REJECT: assert property (@(posedge clk) disable iff (sys_rst) // R4
		(rx_enable && state_reg == UARX_START && bit_done &&
		uarx_vote({vote_reg[1:0], serial_in})) |=> state_reg == UARX_HUNT)
		else $error("Noisy start bit not rejected.");
	AST_START_OK: assert property (@(posedge clk) disable iff (sys_rst) // R5
		(rx_enable && state_reg == UARX_START && bit_done &&
		!uarx_vote({vote_reg[1:0], serial_in})) |=> state_reg == UARX_DATA)
		else $error("Valid start bit not accepted.");
	AST_PHASE_RANGE: assert property (@(posedge clk) disable iff (sys_rst) // R6
		double_speed_select && state_reg != UARX_HUNT && $stable(double_speed_select)
		|-> phase_reg <= 4'h8)
		else $error("Phase beyond eight states in double speed.");
	AST_FE: assert property (@(posedge clk) disable iff (sys_rst) // R9
		(rx_enable && state_reg == UARX_STOP && bit_done) |=>
		frame_valid && frame_error_flag == !$past(uarx_vote({vote_reg[1:0], serial_in})))
		else $error("Frame error flag wrong.");
	AST_HUNT_AFTER_STOP: assert property (@(posedge clk) disable iff (sys_rst) // R10
		frame_valid |-> state_reg == UARX_HUNT)
		else $error("Not hunting after stop vote.");
	AST_DISABLE: assert property (@(posedge clk) disable iff (sys_rst) // R14
		!rx_enable |=> state_reg == UARX_HUNT && !frame_valid)
		else $error("Disable did not abandon frame.");
	AST_NBITS: assert property (@(posedge clk) disable iff (sys_rst) // R11
		state_reg != UARX_HUNT |-> nbits_reg >= UARX_BITS_MIN && nbits_reg <= 4'(MAX_BITS))
		else $error("Frame length out of range.");
	// A short bit would let the centre samples drift by one per bit across a long frame.
	AST_NORMAL_SIXTEEN: assert property (@(posedge clk) disable iff (sys_rst) // R6
		(!double_speed_select && sample_tick && state_reg != UARX_HUNT && phase_reg == 4'hF)
		|=> phase_reg == 4'h0)
		else $error("Normal mode bit does not have sixteen states.");
	AST_DOUBLE_EIGHT: assert property (@(posedge clk) disable iff (sys_rst) // R6
		(double_speed_select && sample_tick && state_reg != UARX_HUNT && phase_reg == 4'h8)
		|=> phase_reg == 4'h1)
		else $error("Double speed bit does not have eight states.");
endmodule : uarx_recovery
`default_nettype wire

//--- tb/uarx_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module uarx_tx_model (
	input wire logic clk,
	input wire logic sample_tick,
	input wire logic send,
	input wire logic dbl,
	input wire logic [3:0] nbits,
	input wire logic [9:0] data,
	input wire logic stop_val,
	output logic line
);
	int idx = -1;
	int ph = 0;
	initial line = 1'b1;
	// Bits last exactly one receiver bit time, so the rate error is nil.
	always @(negedge clk) begin
		if (send && idx < 0) begin
			idx = 0;
			ph = 0;
		end else if (idx >= 0 && sample_tick) begin
			line <= (idx == 0) ? 1'b0 : (idx <= nbits) ? data[idx-1] : stop_val;
			ph = ph + 1;
			if (ph == (dbl ? 8 : 16)) begin
				ph = 0;
				idx = (idx > nbits) ? -1 : idx + 1;
			end
		end else if (idx < 0 && sample_tick) begin
			line <= 1'b1; // Idle high, as the pull-up holds it.
		end
	end
endmodule : uarx_tx_model
`default_nettype wire

//--- tb/test_uarx_recovery.sv
`timescale 1ns/1ps
`default_nettype none
module test_uarx_recovery;
	import uarx_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rx_enable = 1'b1;
	logic dbl = 1'b0;
	logic sample_tick = 1'b0;
	logic noise_n = 1'b1;
	logic send = 1'b0;
	logic stop_val = 1'b1;
	logic [3:0] nbits = 4'h8;
	logic [9:0] data = 10'h000;
	logic tx_line;
	logic [9:0] rx_data;
	logic frame_error_flag;
	logic frame_valid;
	logic rx_busy;
	int fails = 0;
	int n_compared = 0;
	// Clock and a tick on every other cycle.
	always #4 clk = ~clk;
	always @(negedge clk) sample_tick <= ~sample_tick & ~sys_rst;
	uarx_tx_model tx_u (.clk(clk), .sample_tick(sample_tick), .send(send), .dbl(dbl),
		.nbits(nbits), .data(data), .stop_val(stop_val), .line(tx_line));
	uarx_recovery dut_u (.clk(clk), .sys_rst(sys_rst), .rx_enable(rx_enable),
		.double_speed_select(dbl), .sample_tick(sample_tick), .serial_in(tx_line & noise_n),
		.frame_bits(nbits), .rx_data(rx_data), .frame_error_flag(frame_error_flag),
		.frame_valid(frame_valid), .rx_busy(rx_busy));
	task automatic complete_run;
		if (fails == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Waits a bounded span for the done pulse; it stands one cycle only.
	task automatic wait_frame(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 800 && !seen; i++) begin
			@(posedge clk);
			#1;
			seen = frame_valid;
		end
	endtask : wait_frame
	task automatic frame(input logic d, input logic [3:0] nb, input logic [9:0] v,
		input logic s);
		logic seen;
		@(negedge clk);
		dbl <= d;
		nbits <= nb;
		data <= v;
		stop_val <= s;
		send <= 1'b1;
		@(negedge clk);
		send <= 1'b0;
		wait_frame(seen);
		chk({9'h000, seen}, 10'h001);
		chk(rx_data, v & ((10'h001 << nb) - 10'h001));
		chk({9'h000, frame_error_flag}, {9'h000, ~s});
		chk({9'h000, rx_busy}, 10'h001);
		// Busy falls one cycle after the done pulse, as the receiver is hunting again.
		@(posedge clk);
		#1;
		chk({9'h000, rx_busy}, 10'h000);
		repeat (40) @(negedge clk);
	endtask : frame
	// Both modes, length limits, good and bad stop bits.
	task automatic sc_frames;
		logic [9:0] pat [4] = '{10'h0A5, 10'h3C3, 10'h015, 10'h1B6};
		logic [3:0] len [4] = '{4'h8, 4'hA, 4'h5, 4'h9};
		for (int i = 0; i < 4; i++) frame(i[0], len[i], pat[i], ~i[1]);
	endtask : sc_frames
	// A short low spike must be dropped, then a real frame still decodes.
	task automatic sc_noise;
		logic seen;
		@(negedge clk);
		noise_n <= 1'b0;
		repeat (6) @(negedge clk);
		noise_n <= 1'b1;
		wait_frame(seen);
		chk({9'h000, seen}, 10'h000);
		frame(1'b0, 4'h8, 10'h05A, 1'b1);
	endtask : sc_noise
	// Dropping the enable mid-frame loses that frame with no pulse.
	task automatic sc_disable;
		logic seen;
		@(negedge clk);
		send <= 1'b1;
		@(negedge clk);
		send <= 1'b0;
		repeat (100) @(negedge clk);
		chk({9'h000, rx_busy}, 10'h001);
		rx_enable <= 1'b0;
		wait_frame(seen);
		chk({9'h000, seen}, 10'h000);
		chk({9'h000, rx_busy}, 10'h000);
		@(negedge clk);
		rx_enable <= 1'b1;
		frame(1'b0, 4'h7, 10'h06D, 1'b1);
	endtask : sc_disable
	initial begin
		#400000;
		fails++;
		complete_run();
	end
	initial begin
		repeat (5) @(negedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(negedge clk);
		sc_frames();
		sc_noise();
		sc_disable();
		complete_run();
	end
endmodule : test_uarx_recovery
`default_nettype wire
